//--- pmd_pkg.sv
// Constants and register map of the dual motor pulse width controller
// Function
// - Each of the two motors keeps its own duty setting driving its output.
// - Power-up or power-down low clears both duty settings; zero means half period.
// - Nonzero duty sets the high time in clock cycles against the period.
// - Changing one motor's duty changes only that motor's output.
// - Power-down low puts the block in standby; software uses it when idle.
// - Each motor's period is the clock divided by its period divider.
// - Writing zero pulse count stops that motor at once, outputs low.
// - In power-down or while a motor is off its output stays low.
package pmd_pkg;
  localparam int          MOTORS      = 2;
  localparam int          DUTY_W      = 8;
  localparam int          PERIOD_W    = 8;
  localparam int          COUNT_W     = 11;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_PERIOD0 = 8'h00;
  localparam logic [7:0]  OFS_DUTY0   = 8'h04;
  localparam logic [7:0]  OFS_COUNT0  = 8'h08;
  localparam logic [7:0]  OFS_PERIOD1 = 8'h10;
  localparam logic [7:0]  OFS_DUTY1   = 8'h14;
  localparam logic [7:0]  OFS_COUNT1  = 8'h18;
  localparam logic [7:0]  OFS_STATUS  = 8'h20;
  localparam logic [7:0]  DUTY_RST    = 8'h00;
  localparam logic [7:0]  PERIOD_RST  = 8'h85;
  localparam int          ST_RUN_POS  = 0;
  localparam int          ST_DRV_POS  = 2;
  localparam int          ST_PD_POS   = 4;
endpackage : pmd_pkg

//--- pmd_chan.sv
// One motor drive channel: period divider, pulse counter and duty compare
`timescale 1ns/1ps
module pmd_chan
  import pmd_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          stop,
  input  wire logic [pmd_pkg::PERIOD_W-1:0]  period,
  input  wire logic [pmd_pkg::DUTY_W-1:0]    duty,
  input  wire logic                          load,
  input  wire logic [pmd_pkg::COUNT_W-1:0]   load_val,
  output logic                               running,
  output logic                               drive
);
  import pmd_pkg::*;

  logic [PERIOD_W-1:0] phase_r;
  logic [PERIOD_W-1:0] phase_nxt;
  logic [COUNT_W-1:0]  pulses_r;
  logic [COUNT_W-1:0]  pulses_nxt;
  logic                drive_r;
  logic                drive_nxt;
  logic [DUTY_W-1:0]   width;

  always_comb begin
    width = (duty == DUTY_RST) ? {1'b0, period[PERIOD_W-1:1]} : duty;
    phase_nxt  = phase_r;
    pulses_nxt = pulses_r;
    if (stop) begin
      phase_nxt  = '0;
      pulses_nxt = '0;
    end else if (load) begin
      phase_nxt  = '0;
      pulses_nxt = load_val;
    end else if (pulses_r != '0 && period != '0) begin
      if (phase_r >= period - 8'h01) begin
        phase_nxt  = '0;
        pulses_nxt = pulses_r - 11'h001;
      end else begin
        phase_nxt = phase_r + 8'h01;
      end
    end
    drive_nxt = (pulses_nxt != '0) && (period != '0) && (phase_nxt < width);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r  <= '0;
      pulses_r <= '0;
      drive_r  <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      pulses_r <= pulses_nxt;
      drive_r  <= drive_nxt;
    end
  end

  assign running = (pulses_r != '0) && (period != '0);
  assign drive   = drive_r;

  sequence zero_load_s;
    load && load_val == '0 && !stop;
  endsequence

  zero_stop_a: assert property (@(posedge core_clk) disable iff (!resetn)
    zero_load_s |=> !drive && !running)
    else $error("zero pulse count did not stop the channel");

  idle_low_a: assert property (@(posedge core_clk) disable iff (!resetn)
    drive |-> running)
    else $error("drive high while motor off");

  rise_start_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(drive) |-> phase_r == '0)
    else $error("drive rose away from period start");

  fall_width_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ($fell(drive) && !$past(stop) && !$past(load) && running && $stable(duty) && $stable(period))
      |-> phase_r == width)
    else $error("drive high time differs from duty width");

  wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (running && !stop && !load && phase_r == period - 8'h01 && $stable(period)) |=> phase_r == '0)
    else $error("period divider did not wrap");
endmodule : pmd_chan

//--- pmd_top.sv
// APB register file and two drive channels with power-down control
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pmd_top
  import pmd_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pmd_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        power_down_n,
  output logic [pmd_pkg::MOTORS-1:0]       drive_out,
  output logic                             standby
);
  import pmd_pkg::*;

  logic                 pd_meta_r;
  logic                 pd_sync_r;
  logic                 pd_active;
  logic [DUTY_W-1:0]    duty_r   [MOTORS];
  logic [DUTY_W-1:0]    duty_nxt [MOTORS];
  logic [PERIOD_W-1:0]  period_r   [MOTORS];
  logic [PERIOD_W-1:0]  period_nxt [MOTORS];
  logic [MOTORS-1:0]    load;
  logic [MOTORS-1:0]    running;
  logic [MOTORS-1:0]    drive;
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic                 slverr_r;
  logic                 slverr_nxt;
  logic                 wr_acc;
  logic                 setup;
  logic                 mapped;

  // Power-down pin synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pd_meta_r <= 1'b0;
      pd_sync_r <= 1'b0;
    end else begin
      pd_meta_r <= power_down_n;
      pd_sync_r <= pd_meta_r;
    end
  end
  assign pd_active = !pd_sync_r;
  assign standby   = pd_active;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !pd_active;
  assign mapped = paddr inside {OFS_PERIOD0, OFS_DUTY0, OFS_COUNT0,
                                OFS_PERIOD1, OFS_DUTY1, OFS_COUNT1, OFS_STATUS};

  always_comb begin
    for (int m = 0; m < MOTORS; m++) begin
      duty_nxt[m]   = duty_r[m];
      period_nxt[m] = period_r[m];
    end
    if (pd_active) begin
      for (int m = 0; m < MOTORS; m++) begin
        duty_nxt[m] = DUTY_RST;
      end
    end else if (wr_acc) begin
      unique case (paddr)
        OFS_DUTY0:   duty_nxt[0]   = pwdata[DUTY_W-1:0];
        OFS_DUTY1:   duty_nxt[1]   = pwdata[DUTY_W-1:0];
        OFS_PERIOD0: period_nxt[0] = pwdata[PERIOD_W-1:0];
        OFS_PERIOD1: period_nxt[1] = pwdata[PERIOD_W-1:0];
        default:     ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int m = 0; m < MOTORS; m++) begin
        duty_r[m]   <= DUTY_RST;
        period_r[m] <= PERIOD_RST;
      end
    end else begin
      for (int m = 0; m < MOTORS; m++) begin
        duty_r[m]   <= duty_nxt[m];
        period_r[m] <= period_nxt[m];
      end
    end
  end

  assign load[0] = wr_acc && paddr == OFS_COUNT0;
  assign load[1] = wr_acc && paddr == OFS_COUNT1;

  // Read data captured in the setup cycle
  always_comb begin
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (setup) begin
      slverr_nxt = !mapped;
      prdata_nxt = '0;
      unique case (paddr)
        OFS_DUTY0:   prdata_nxt[DUTY_W-1:0]   = duty_r[0];
        OFS_DUTY1:   prdata_nxt[DUTY_W-1:0]   = duty_r[1];
        OFS_PERIOD0: prdata_nxt[PERIOD_W-1:0] = period_r[0];
        OFS_PERIOD1: prdata_nxt[PERIOD_W-1:0] = period_r[1];
        OFS_STATUS: begin
          prdata_nxt[ST_RUN_POS +: MOTORS] = running;
          prdata_nxt[ST_DRV_POS +: MOTORS] = drive;
          prdata_nxt[ST_PD_POS]            = pd_active;
        end
        default:     ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && slverr_r;

  generate
    for (genvar g = 0; g < MOTORS; g++) begin : g_chan
      pmd_chan u_chan (
        .core_clk (core_clk),
        .resetn   (resetn),
        .stop     (pd_active),
        .period   (period_r[g]),
        .duty     (duty_r[g]),
        .load     (load[g]),
        .load_val (pwdata[COUNT_W-1:0]),
        .running  (running[g]),
        .drive    (drive[g])
      );
    end
  endgenerate

  assign drive_out = drive;

  sequence pd_held_s;
    (!power_down_n)[*3];
  endsequence

  sequence wr_duty0_s;
    wr_acc && paddr == OFS_DUTY0;
  endsequence

  sequence wr_duty1_s;
    wr_acc && paddr == OFS_DUTY1;
  endsequence

  sequence unmapped_setup_s;
    setup && !mapped;
  endsequence

  pd_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    pd_held_s |=> duty_r[0] == DUTY_RST && duty_r[1] == DUTY_RST)
    else $error("duty not cleared in power-down");

  pd_low_a: assert property (@(posedge core_clk) disable iff (!resetn)
    pd_held_s |=> drive_out == '0 && standby)
    else $error("outputs not low in power-down");

  duty_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_acc && paddr == OFS_DUTY1) |=> pd_active || duty_r[1] == DUTY_W'($past(pwdata)))
    else $error("duty write not stored");

  duty_indep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_acc && paddr == OFS_DUTY0) |=> $stable(duty_r[1]) && $stable(period_r[1]))
    else $error("one motor write disturbed the other");

  unmapped_err_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && !mapped) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped access without error");

  standby_lag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(resetn, 2) |-> standby == !$past(power_down_n, 2))
    else $error("standby does not follow the synchronised pin");

  pd_stop_a: assert property (@(posedge core_clk) disable iff (!resetn)
    pd_active |=> drive_out == '0)
    else $error("drive not stopped by power-down");

  pd_count_a: assert property (@(posedge core_clk) disable iff (!resetn)
    pd_active |=> running == '0)
    else $error("pulse counters not cleared by power-down");

  pd_wr_ignore_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (psel && penable && pwrite && pd_active && paddr == OFS_PERIOD0) |=> $stable(period_r[0]))
    else $error("write accepted during standby");

  count_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (load[0] && pwdata[COUNT_W-1:0] != '0 && period_r[0] != '0) |=> running[0])
    else $error("pulse count load did not start the motor");

  duty0_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_duty0_s |=> duty_r[0] == DUTY_W'($past(pwdata)))
    else $error("motor 0 duty write not stored");

  duty_indep1_a: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_duty1_s |=> $stable(duty_r[0]) && $stable(period_r[0]))
    else $error("motor 1 write disturbed motor 0");

  unmapped_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    unmapped_setup_s |=> prdata == '0)
    else $error("unmapped read data not zero");

  mapped_ok_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && mapped) ##1 (psel && penable) |-> !pslverr)
    else $error("mapped access flagged as error");

  status_pd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && paddr == OFS_STATUS) |=> prdata[ST_PD_POS] == $past(pd_active))
    else $error("status power-down bit wrong");
endmodule : pmd_top

//--- pmd_motor_model.sv
// Piezo motor phase model measuring each drive pulse width
`timescale 1ns/1ps
module pmd_motor_model (
  input  wire logic        core_clk,
  input  wire logic        drive,
  output logic [7:0]       width,
  output logic             done
);
  logic [7:0] cnt_r;
  // Phase load sees one high time per pulse
  always_ff @(posedge core_clk) begin
    done  <= drive == 1'b0 && cnt_r != 8'h00;
    width <= cnt_r;
    cnt_r <= drive ? cnt_r + 8'h01 : 8'h00;
  end
endmodule : pmd_motor_model

//--- piezo_motor_duty_cycle_control_test.sv
// Self-checking testbench of the dual motor pulse width controller
`timescale 1ns/1ps
module piezo_motor_duty_cycle_control_test;
  import pmd_pkg::*;
  logic        core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, power_down_n = 1;
  logic [7:0]  paddr = 8'h00, d0, d1;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, standby;
  logic [1:0]  drive_out, done;
  logic [7:0]  width [2];
  logic [32:0] exp_rd [$];
  logic [7:0]  exp_w0 [$], exp_w1 [$];
  int          num_errors = 0, n_checks = 0;

  pmd_top pmd_top_i (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n(power_down_n), .drive_out(drive_out), .standby(standby));
  for (genvar g = 0; g < 2; g++) begin : mot
    pmd_motor_model pmd_motor_model_i (.core_clk(core_clk), .drive(drive_out[g]), .width(width[g]),
      .done(done[g]));
  end

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [32:0] e, input logic [32:0] a);
    n_checks++;
    if (a !== e) begin
      num_errors++;
      $display("wrong value at %0t: exp %h got %h", $time, e, a);
    end
  endtask : cmp

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_clk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_rd.push_back({err, d});
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wait_sb();
    int k;
    wait_clk(3);
    k = 0;
    while (standby !== 1'b0 && k < 50) begin
      @(posedge core_clk);
      k++;
    end
    if (standby !== 1'b0) begin
      num_errors++;
      end_of_test();
    end
  endtask : wait_sb

  // Result watcher takes the oldest note per result
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      cmp(exp_rd.pop_front(), {pslverr, prdata});
    if (done[0] === 1'b1 && exp_w0.size() > 0)
      cmp({25'h0, exp_w0.pop_front()}, {25'h0, width[0]});
    if (done[1] === 1'b1 && exp_w1.size() > 0)
      cmp({25'h0, exp_w1.pop_front()}, {25'h0, width[1]});
  end

  initial begin
    void'($urandom(10));
    wait_clk(2);
    resetn <= 1'b1;
    wait_sb();
    apb(1'b0, OFS_DUTY0, 32'h0, 1'b0);
    apb(1'b0, OFS_DUTY1, 32'h0, 1'b0);
    apb(1'b0, OFS_PERIOD0, {24'h0, PERIOD_RST}, 1'b0);
    apb(1'b0, 8'h30, 32'h0, 1'b1);
    $display("test reset values done");
    for (int r = 0; r < 4; r++) begin
      d0 = (r == 0) ? 8'h00 : 8'($urandom_range(1, 4));
      d1 = 8'($urandom_range(1, 5));
      apb(1'b1, OFS_PERIOD0, 32'h8, 1'b0);
      apb(1'b1, OFS_PERIOD1, 32'ha, 1'b0);
      apb(1'b1, OFS_DUTY0, {24'h0, d0}, 1'b0);
      apb(1'b1, OFS_DUTY1, {24'h0, d1}, 1'b0);
      repeat (3) exp_w0.push_back(d0 == 8'h00 ? 8'h04 : d0);
      repeat (3) exp_w1.push_back(d1);
      apb(1'b1, OFS_COUNT0, 32'h3, 1'b0);
      apb(1'b1, OFS_COUNT1, 32'h3, 1'b0);
      wait_clk(40);
      cmp(33'h0, 33'(exp_w0.size() + exp_w1.size()));
    end
    $display("test pulse widths done");
    apb(1'b1, OFS_COUNT0, 32'h64, 1'b0);
    wait_clk(21);
    apb(1'b1, OFS_COUNT0, 32'h0, 1'b0);
    wait_clk(8);
    cmp(33'h0, {32'h0, drive_out[0]});
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0);
    $display("test stop done");
    apb(1'b1, OFS_DUTY1, 32'h3, 1'b0);
    apb(1'b1, OFS_COUNT1, 32'hc8, 1'b0);
    wait_clk(5);
    power_down_n <= 1'b0;
    wait_clk(4);
    cmp(33'h1, {32'h0, standby});
    cmp(33'h0, {31'h0, drive_out});
    apb(1'b1, OFS_PERIOD0, 32'h20, 1'b0);
    power_down_n <= 1'b1;
    wait_sb();
    apb(1'b0, OFS_DUTY1, 32'h0, 1'b0);
    apb(1'b0, OFS_PERIOD0, 32'h8, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0);
    $display("test power down done");
    end_of_test();
  end
endmodule : piezo_motor_duty_cycle_control_test
